// ### hdl/maceng_pkg.sv
package maceng_pkg;
    // ********************
    // Bus and map
    // ********************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_OPERAND_A = 8'h08;
    localparam logic [7:0] OFS_OPERAND_B = 8'h0C;
    localparam logic [7:0] OFS_ACC_LOW = 8'h10;
    localparam logic [7:0] OFS_ACC_TOP = 8'h14;
    localparam logic [7:0] OFS_ROUNDED = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ********************
    // Config and status fields
    // ********************
    localparam int CFG_MS = 0;
    localparam int CFG_FM = 1;
    localparam int CFG_SAT = 2;
    localparam int CFG_CA = 3;
    localparam int CFG_SD = 4;
    localparam int CFG_SC = 5;
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam int STA_N = 0;
    localparam int STA_SO = 1;
    localparam int STA_Z = 2;
    localparam int STA_HO = 3;
    localparam logic [3:0] STA_RESET = 4'h4;
    // ********************
    // Rounding and overflow constants
    // ********************
    localparam logic [15:0] RND_HALF = 16'h8000;
    localparam logic [15:0] SAT_POS = 16'h7FFF;
    localparam logic [15:0] SAT_NEG = 16'h8000;
    localparam logic [15:0] RND_RESET = 16'h0000;
    localparam logic [7:0] TOP_POS_MAX = 8'h7F;
    localparam logic [7:0] TOP_NEG_MIN = 8'h80;
endpackage : maceng_pkg

// ### hdl/maceng_mult_acc_engine.sv
`timescale 1ns/1ps
// How it works
// - Signed 16x16 product added to 40-bit accumulator
// - Three pipeline stages, one clock each
// - Operand B low write starts; multiply next
// - Stage two adds product into accumulator
// - Flags update when stage two ends
// - Next start allowed during stage two
// - Rounded, saturated result after stage three
// - Clear bit zeroes accumulator, flags and itself in one cycle
// - Multiply-only overwrites accumulator, ready three cycles after start
// - Multiply-only leaves hard overflow untouched
// - Shift bit shifts one cycle, self-clears
// - Direction bit: zero left, one right
// - Right shift copies bit 39 down
// - Shifts leave status flags alone
// - Unbiased round of bits 31-16
// - Round after stage two, shift, low write
// - Rounding never touches accumulator, mode-blind
// - Saturate to 7FFF or 8000 when enabled
// - Rounded holds low 16 bits; sign in flag
// - Fraction mode doubles product, point at 31
// - Hard overflow sticky on top byte crossing
// - Soft overflow tracks bit 31 overflow
// - Zero and negative flags follow result
module maceng_mult_acc_engine (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address
    input wire logic [maceng_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address
    input wire logic [maceng_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import maceng_pkg::*;

    // ********************
    // Bus slave
    // ********************
    logic aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg;

    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready = !w_have_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    wire wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
    wire [7:0] wa = {awaddr_reg[7:2], 2'b00};
    wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
    wire wr_cfg = wr_fire && wa == OFS_CONFIG && wstrb_reg[0];
    wire wr_sta = wr_fire && wa == OFS_STATUS && wstrb_reg[0];
    wire wr_opa = wr_fire && wa == OFS_OPERAND_A;
    wire wr_opb = wr_fire && wa == OFS_OPERAND_B;
    wire wr_acc = wr_fire && wa == OFS_ACC_LOW;
    wire wr_top = wr_fire && wa == OFS_ACC_TOP && wstrb_reg[0];
    wire wr_hit = wr_fire && (wa == OFS_CONFIG || wa == OFS_STATUS || wa == OFS_OPERAND_A
        || wa == OFS_OPERAND_B || wa == OFS_ACC_LOW || wa == OFS_ACC_TOP || wa == OFS_ROUNDED);

    // ********************
    // Engine state
    // ********************
    logic [5:0] cfg_reg, cfg_next;
    logic [3:0] sta_reg, sta_next;
    logic [15:0] opa_reg, opa_next, opb_reg, opb_next;
    logic [39:0] acc_reg, acc_next, prod_reg;
    logic [15:0] rnd_reg;
    logic s1_valid_reg, s1_clear_reg, s2_valid_reg, round_go_reg;

    // Low-byte strobe is the start trigger
    wire start = wr_opb && wstrb_reg[0];
    wire shift_now = cfg_reg[CFG_SC];
    wire clear_now = s1_valid_reg && s1_clear_reg;

    // Stage one: signed multiply, doubled in fraction mode
    wire signed [31:0] prod_raw = $signed(opa_reg) * $signed(opb_reg);
    wire [39:0] prod_ext = {{8{prod_raw[31]}}, prod_raw};
    wire [39:0] prod_val = cfg_reg[CFG_FM] ? {prod_ext[38:0], 1'b0} : prod_ext;

    // Stage two: add to accumulator or to zero
    wire [39:0] acc_base = cfg_reg[CFG_MS] ? 40'h00_0000_0000 : acc_reg;
    wire [39:0] sum = acc_base + prod_reg;
    wire top_cross = (acc_reg[39:32] == TOP_POS_MAX && sum[39:32] == TOP_NEG_MIN)
        || (acc_reg[39:32] == TOP_NEG_MIN && sum[39:32] == TOP_POS_MAX);
    wire hard_set = !cfg_reg[CFG_MS] && top_cross;
    wire soft_ovf = !(&sum[39:31]) && (|sum[39:31]);

    // Shifter: right shift keeps sign from bit 39
    wire [39:0] acc_shl = {acc_reg[38:0], 1'b0};
    wire [39:0] acc_shr = {acc_reg[39], acc_reg[39:1]};
    wire [39:0] acc_shift = cfg_reg[CFG_SD] ? acc_shr : acc_shl;

    // Rounding engine reads the accumulator only
    wire [15:0] rnd_low = acc_reg[15:0];
    wire rnd_up = rnd_low > RND_HALF || (rnd_low == RND_HALF && acc_reg[16]);
    wire [24:0] rnd_sum = {acc_reg[39], acc_reg[39:16]} + {24'h00_0000, rnd_up};
    wire rnd_ovf = !(&rnd_sum[24:15]) && (|rnd_sum[24:15]);
    wire [15:0] rnd_sat = rnd_sum[24] ? SAT_NEG : SAT_POS;
    wire [15:0] rnd_val = (cfg_reg[CFG_SAT] && rnd_ovf) ? rnd_sat : rnd_sum[15:0];

    // Byte-lane merge of a bus write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // ********************
    // Next-state logic
    // ********************
    always_comb begin
        acc_next = acc_reg;
        if (clear_now) begin
            acc_next = '0;
        end
        if (shift_now) begin
            acc_next = acc_shift;
        end
        if (s2_valid_reg) begin
            acc_next = sum;
        end
        if (wr_acc) begin
            acc_next[31:0] = merge(acc_reg[31:0], wdata_reg, wstrb_reg);
        end
        if (wr_top) begin
            acc_next[39:32] = wdata_reg[7:0];
        end
    end

    always_comb begin
        sta_next = sta_reg;
        if (wr_sta) begin
            sta_next = wdata_reg[3:0];
        end
        // Hardware beats a same-cycle software write; flags unaffected by shifts
        if (clear_now) begin
            sta_next = '0;
        end
        if (s2_valid_reg) begin
            sta_next[STA_Z] = sum == 40'h00_0000_0000;
            sta_next[STA_N] = sum[39];
            sta_next[STA_SO] = soft_ovf;
            if (hard_set) begin
                sta_next[STA_HO] = 1'b1;
            end
        end
    end

    always_comb begin
        cfg_next = cfg_reg;
        if (shift_now) begin
            cfg_next[CFG_SC] = 1'b0;
        end
        if (clear_now) begin
            cfg_next[CFG_CA] = 1'b0;
        end
        if (wr_cfg) begin
            cfg_next = wdata_reg[5:0];
        end
    end

    // Operands use only the two low lanes of the merged word
    wire [31:0] opa_merged = merge({16'h0000, opa_reg}, wdata_reg, wstrb_reg);
    wire [31:0] opb_merged = merge({16'h0000, opb_reg}, wdata_reg, wstrb_reg);
    assign opa_next = wr_opa ? opa_merged[15:0] : opa_reg;
    assign opb_next = wr_opb ? opb_merged[15:0] : opb_reg;

    // ********************
    // Registers
    // ********************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg <= CFG_RESET;
            sta_reg <= STA_RESET;
            opa_reg <= '0;
            opb_reg <= '0;
            acc_reg <= '0;
            prod_reg <= '0;
        end else begin
            cfg_reg <= cfg_next;
            sta_reg <= sta_next;
            opa_reg <= opa_next;
            opb_reg <= opb_next;
            acc_reg <= acc_next;
            if (s1_valid_reg) begin
                prod_reg <= prod_val;
            end
        end
    end

    // Pipeline stage markers; a start may overlap stage two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_valid_reg <= 1'b0;
            s1_clear_reg <= 1'b0;
            s2_valid_reg <= 1'b0;
            round_go_reg <= 1'b0;
        end else begin
            s1_valid_reg <= start;
            s1_clear_reg <= start && cfg_reg[CFG_CA];
            s2_valid_reg <= s1_valid_reg;
            round_go_reg <= s2_valid_reg || shift_now || (wr_acc && wstrb_reg[0]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rnd_reg <= RND_RESET;
        end else if (round_go_reg) begin
            rnd_reg <= rnd_val;
        end
    end

    // ********************
    // Bus handshakes
    // ********************
    wire [31:0] rd_mux =
        ra == OFS_CONFIG ? {26'h000_0000, cfg_reg} :
        ra == OFS_STATUS ? {28'h000_0000, sta_reg} :
        ra == OFS_OPERAND_A ? {16'h0000, opa_reg} :
        ra == OFS_OPERAND_B ? {16'h0000, opb_reg} :
        ra == OFS_ACC_LOW ? acc_reg[31:0] :
        ra == OFS_ACC_TOP ? {24'h00_0000, acc_reg[39:32]} :
        ra == OFS_ROUNDED ? {16'h0000, rnd_reg} : 32'h0000_0000;
    wire rd_hit = ra == OFS_CONFIG || ra == OFS_STATUS || ra == OFS_OPERAND_A
        || ra == OFS_OPERAND_B || ra == OFS_ACC_LOW || ra == OFS_ACC_TOP || ra == OFS_ROUNDED;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ********************
    // Checks
    // ********************
    a_multiply_latency: assert property (
        @(posedge aclk) disable iff (!aresetn)
        start |=> ##1 (prod_reg == $past(prod_val)))
        else $error("product not registered one cycle after start");

    a_multiply_only_result: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s2_valid_reg && cfg_reg[CFG_MS] && !wr_acc && !wr_top)
        |=> acc_reg == $past(prod_reg))
        else $error("multiply-only result not in accumulator");

    a_clear_effect: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (start && cfg_reg[CFG_CA] && !wr_cfg)
        ##1 !wr_acc && !wr_top && !shift_now && !wr_cfg && !s2_valid_reg
        |=> acc_reg == 40'h00_0000_0000 && !cfg_reg[CFG_CA])
        else $error("clear did not zero accumulator or self-clear");

    a_hard_ovf_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s2_valid_reg && cfg_reg[CFG_MS] && !wr_sta && !clear_now)
        |=> $stable(sta_reg[STA_HO]))
        else $error("hard overflow changed in multiply-only mode");

    a_shift_done: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (shift_now && !wr_cfg && !s2_valid_reg && !wr_acc && !wr_top)
        |=> !cfg_reg[CFG_SC]
            && ($past(cfg_reg[CFG_SD]) || acc_reg == {$past(acc_reg[38:0]), 1'b0}))
        else $error("shift did not complete in one cycle");

    a_shift_right_sign: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (shift_now && cfg_reg[CFG_SD] && !s2_valid_reg && !wr_acc && !wr_top)
        |=> acc_reg[39] == $past(acc_reg[39]) && acc_reg[38:0] == $past(acc_reg[39:1]))
        else $error("right shift not sign-extended");

    a_shift_flags_kept: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (shift_now && !s2_valid_reg && !clear_now && !wr_sta) |=> $stable(sta_reg))
        else $error("shift altered status flags");

    a_round_after_shift: assert property (
        @(posedge aclk) disable iff (!aresetn)
        shift_now |=> round_go_reg ##1 rnd_reg == $past(rnd_val))
        else $error("rounding not refreshed after shift");

    a_round_half_even: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (round_go_reg && !cfg_reg[CFG_SAT] && acc_reg[15:0] == RND_HALF && !acc_reg[16])
        |=> rnd_reg == $past(acc_reg[31:16]))
        else $error("tie with even upper half did not truncate");

    a_saturate_pos: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (round_go_reg && cfg_reg[CFG_SAT] && !acc_reg[39] && acc_reg[38:31] != 8'h00)
        |=> rnd_reg == SAT_POS)
        else $error("positive overflow not saturated");

    a_zero_flag: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s2_valid_reg
        |=> sta_reg[STA_Z] == (acc_reg == 40'h00_0000_0000) || $past(wr_acc) || $past(wr_top))
        else $error("zero flag disagrees with accumulator");
endmodule : maceng_mult_acc_engine

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
    import maceng_pkg::*;
    // ********************
    // Clock, reset and bus
    // ********************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int err_count = 0;
    int total_checks = 0;

    maceng_mult_acc_engine uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // ********************
    // Bus tasks
    // ********************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Readies are combinational on stable inputs, so mid-cycle equals the next edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        logic a_go, w_go, b_go, a_done, w_done;
        a_done = 1'b0;
        w_done = 1'b0;
        b_go = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_go) begin
            @(negedge aclk);
            a_go = !a_done && s_axi_awready;
            w_go = !w_done && s_axi_wready;
            b_go = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (a_go) begin
                s_axi_awvalid <= 1'b0;
                a_done = 1'b1;
            end
            if (w_go) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
            if (b_go) s_axi_bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic a_go, r_go, a_done;
        a_done = 1'b0;
        r_go = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_go) begin
            @(negedge aclk);
            a_go = !a_done && s_axi_arready;
            r_go = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (a_go) begin
                s_axi_arvalid <= 1'b0;
                a_done = 1'b1;
            end
            if (r_go) s_axi_rready <= 1'b0;
        end
    endtask : rd

    task automatic wok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] resp;
        wr(a, d, 4'hF, resp);
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask : wok

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        logic [1:0] resp;
        rd(a, d, resp);
        chk(name, exp, d);
        chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask : rchk

    // Result lands three edges after the start write
    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask : settle

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] resp;
        rchk(OFS_CONFIG, 32'h0, "config");
        rchk(OFS_STATUS, 32'h4, "status");
        rchk(OFS_ROUNDED, 32'h0, "rounded");
        rd(8'h1C, d, resp);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(8'h1C, 32'hFFFF_FFFF, 4'hF, resp);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        $display("test reset done");
    endtask : t_reset

    task automatic t_mult_only();
        wok(OFS_CONFIG, 32'h01);
        wok(OFS_OPERAND_A, 32'h1234);
        wok(OFS_OPERAND_B, 32'hFEDC);
        settle();
        rchk(OFS_ACC_LOW, 32'hFFEB_3CB0, "acc low");
        rchk(OFS_ACC_TOP, 32'hFF, "acc top");
        rchk(OFS_STATUS, 32'h01, "status");
        rchk(OFS_ROUNDED, 32'hFFEB, "rounded");
        $display("test mult_only done");
    endtask : t_mult_only

    task automatic t_hard_ovf();
        wok(OFS_CONFIG, 32'h00);
        wok(OFS_ACC_TOP, 32'h7F);
        wok(OFS_ACC_LOW, 32'hFFFF_FFFF);
        wok(OFS_OPERAND_A, 32'h0001);
        wok(OFS_OPERAND_B, 32'h0001);
        settle();
        rchk(OFS_ACC_TOP, 32'h80, "acc top");
        rchk(OFS_STATUS, 32'h0B, "status");
        wok(OFS_CONFIG, 32'h01);
        wok(OFS_OPERAND_B, 32'h0001);
        settle();
        rchk(OFS_ACC_LOW, 32'h1, "acc low");
        rchk(OFS_STATUS, 32'h08, "status");
        wok(OFS_STATUS, 32'h00);
        rchk(OFS_STATUS, 32'h00, "status");
        $display("test hard_ovf done");
    endtask : t_hard_ovf

    // Second start follows the first four cycles later, after its stage two
    task automatic t_frac_mac();
        wok(OFS_CONFIG, 32'h0A);
        wok(OFS_OPERAND_A, 32'h4000);
        wok(OFS_OPERAND_B, 32'h2000);
        wok(OFS_OPERAND_B, 32'hE000);
        settle();
        rchk(OFS_CONFIG, 32'h02, "config");
        rchk(OFS_ACC_LOW, 32'h0, "acc low");
        rchk(OFS_STATUS, 32'h04, "status");
        wok(OFS_OPERAND_B, 32'h2000);
        settle();
        rchk(OFS_ACC_LOW, 32'h1000_0000, "acc low");
        rchk(OFS_ROUNDED, 32'h1000, "rounded");
        $display("test frac_mac done");
    endtask : t_frac_mac

    task automatic t_shift();
        wok(OFS_CONFIG, 32'h00);
        wok(OFS_ACC_TOP, 32'h40);
        wok(OFS_ACC_LOW, 32'h8844_2211);
        wok(OFS_CONFIG, 32'h20);
        rchk(OFS_CONFIG, 32'h00, "config");
        rchk(OFS_ACC_LOW, 32'h1088_4422, "acc low");
        rchk(OFS_ACC_TOP, 32'h81, "acc top");
        rchk(OFS_ROUNDED, 32'h1088, "rounded");
        rchk(OFS_STATUS, 32'h00, "status");
        wok(OFS_CONFIG, 32'h30);
        wok(OFS_CONFIG, 32'h30);
        rchk(OFS_ACC_LOW, 32'h4422_1108, "acc low");
        rchk(OFS_ACC_TOP, 32'hE0, "acc top");
        rchk(OFS_ROUNDED, 32'h4422, "rounded");
        $display("test shift done");
    endtask : t_shift

    task automatic t_round();
        logic [31:0] low [9] = '{32'h0005_8001, 32'h0005_7FFF, 32'h0005_8000, 32'h0006_8000,
                                 32'h7FFF_8000, 32'h7FFF_8000, 32'h1234_0000, 32'h1234_0000,
                                 32'h8000_0000};
        logic [15:0] exp [9] = '{16'h0006, 16'h0005, 16'h0006, 16'h0006,
                                 16'h7FFF, 16'h8000, 16'h8000, 16'h1234, 16'h7FFF};
        logic [7:0] top [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
        logic [31:0] cfg [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h0, 32'h4, 32'h0, 32'h4};
        for (int i = 0; i < 9; i++) begin
            wok(OFS_CONFIG, cfg[i]);
            wok(OFS_ACC_TOP, {24'h0, top[i]});
            wok(OFS_ACC_LOW, low[i]);
            rchk(OFS_ROUNDED, {16'h0, exp[i]}, "rounded");
        end
        $display("test round done");
    endtask : t_round

    // ********************
    // Run control
    // ********************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_mult_only();
        t_hard_ovf();
        t_frac_mac();
        t_shift();
        t_round();
        print_verdict();
    end

    // Whole run needs well under a tenth of this span
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule : tb
